// File: verilog/positioner_tune_and_fieldbus_word.sv
// Tuning sequence control and fieldbus set-point/feedback word handling of a valve positioner.
// Assumes key and mode switch come from pins; all other inputs are on core_clk.
// What this block does
// - Tuning starts only in automatic mode
// - Key held five seconds starts tuning
// - Green indicator flashes very fast during tuning
// - Green indicator flashes slowly after tuning
// - Results stored only after successful run
// - Fault aborts run, red lit, retry allowed
// - Configuration software may also start tuning
// - Master sends sixteen-bit set-point, taken as command
// - Words span 0 to 10000 for 0-100%
// - Output-only profile: user-settable extended ID 1
// - Feedback profile: code 0 reads, 1 writes
`timescale 1ns/1ps
`default_nettype none
module positioner_tune_and_fieldbus_word
    import positioner_pkg::*;
#(
    parameter logic [15:0] TICK_CYCLES = 16'(TICK_CYCLES_DEF)
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Operator panel pins
    input wire logic keyStartPin,
    input wire logic modeManualPin,
    output logic ledGreen,
    output logic ledRed,
    // Configuration software
    input wire logic cfgTuneStart,
    // Tuning engine
    output logic tuneActive,
    input wire logic tuneDone,
    input wire logic tuneFault,
    input wire tune_result_s tuneResult,
    // Nonvolatile parameter store
    output logic nvWrite,
    output tune_result_s nvData,
    // Fieldbus slave front end
    input wire logic profileFeedback,
    input wire bus_req_s busReq,
    output bus_rsp_s busRsp,
    input wire logic extIdWrite,
    input wire logic [3:0] extIdData,
    output logic [3:0] extId1,
    // Control loop side
    input wire logic [13:0] positionFb,
    output logic [13:0] setPoint,
    output logic setPointStb
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic keyMeta;          // Key synchroniser, first stage
        logic keySync;          // Key synchroniser, second stage
        logic modeMeta;         // Mode synchroniser, first stage
        logic modeSync;         // Mode synchroniser, second stage
        tune_state_e state;     // Tuning sequence
        logic [12:0] holdCnt;   // Key hold time in ticks
        logic keyArmed;         // Key released since hold last reached
        logic [9:0] blinkCnt;   // Flash half period counter
        logic blinkPhase;       // Flash phase
        logic ledGreen;
        logic ledRed;
        logic tuneActive;
        tune_result_s result;   // Results held until commit
        logic nvWrite;
        tune_result_s nvData;
        logic [13:0] setPoint;
        logic setPointStb;
        bus_rsp_s rsp;
        logic [3:0] extIdUser;  // User value of extended ID 1
        logic [3:0] extId1;
    } ctl_state_s;

    ctl_state_s cur_ff; // Registered state
    ctl_state_s nxt_cur; // Next state
    logic tickEn; // 1 ms time base enable
    // Combinational helpers of the next state logic
    logic startReq; // A start request accepted this cycle
    logic keyHeld; // Key hold time reached
    logic [13:0] rxValue; // Received value bits
    logic [13:0] fbValue; // Feedback clamped to full scale

    // ------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------
    // Free-running, so its phase against a start is random; hold and
    // flash times are therefore exact to one tick only
    tick_divider #(
        .DIV(TICK_CYCLES)
    ) u_tick (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .tickEn(tickEn)
    );

    // ------------------------------------------------------------
    // Next state logic
    // ------------------------------------------------------------
    // Every field holds unless a branch below changes it
    always_comb
    begin
        nxt_cur = cur_ff;
        // Pins pass two flops before anything looks at them
        nxt_cur.keyMeta = keyStartPin;
        nxt_cur.keySync = cur_ff.keyMeta;
        nxt_cur.modeMeta = modeManualPin;
        nxt_cur.modeSync = cur_ff.modeMeta;
        // Pulses default low
        nxt_cur.nvWrite = 1'b0;
        nxt_cur.setPointStb = 1'b0;
        nxt_cur.rsp.valid = 1'b0;

        // Key hold timer: any release restarts the count
        // Counting ticks, not clocks, keeps the counter at 13 bits
        keyHeld = 1'b0;
        if (!cur_ff.keySync)
        begin
            nxt_cur.holdCnt = 13'h0000;
            // Letting go re-arms the key for the next start
            nxt_cur.keyArmed = 1'b1;
        end
        else if (cur_ff.keyArmed && tickEn)
        begin
            if (cur_ff.holdCnt >= KEY_HOLD_TICKS - 13'h0001)
            begin
                keyHeld = 1'b1;
                nxt_cur.holdCnt = 13'h0000;
            end
            else
            begin
                nxt_cur.holdCnt = cur_ff.holdCnt + 13'h0001;
            end
        end

        // Start from the key or from configuration software, automatic mode only
        // A second start while running or committing is ignored
        startReq = (keyHeld || cfgTuneStart) && !cur_ff.modeSync &&
                   (cur_ff.state != TUNE_RUN) && (cur_ff.state != TUNE_COMMIT);
        if (keyHeld)
        begin
            // Holding on does not retrigger; the key must be let go first
            nxt_cur.keyArmed = 1'b0;
        end

        // Tuning sequence
        case (cur_ff.state)
            TUNE_RUN:
            begin
                // Fault wins over done, so a bad run never reaches the store
                // Switching to manual mid-run is treated as a fault
                if (tuneFault || cur_ff.modeSync)
                begin
                    nxt_cur.state = TUNE_FAULT;
                    nxt_cur.tuneActive = 1'b0;
                end
                else if (tuneDone)
                begin
                    // Latched now, written to the store one cycle later
                    nxt_cur.result = tuneResult;
                    nxt_cur.state = TUNE_COMMIT;
                    nxt_cur.tuneActive = 1'b0;
                end
            end
            TUNE_COMMIT:
            begin
                // Single write of the successful results
                // The store sees exactly one pulse per good run
                nxt_cur.nvWrite = 1'b1;
                nxt_cur.nvData = cur_ff.result;
                nxt_cur.state = TUNE_DONE;
            end
            default:
            begin
                // Idle, done and fault all accept a new run
                // A fresh run restarts the flash in its lit phase
                if (startReq)
                begin
                    nxt_cur.state = TUNE_RUN;
                    nxt_cur.tuneActive = 1'b1;
                    nxt_cur.blinkCnt = 10'h000;
                    nxt_cur.blinkPhase = 1'b1;
                end
            end
        endcase

        // Flash generator, period chosen by the sequence state
        // A start owns the counter in its own cycle, so a tick that
        // lands on it cannot shift the first fast half period
        if (tickEn && !startReq)
        begin
            if ((cur_ff.state == TUNE_RUN && cur_ff.blinkCnt >= BLINK_FAST_TICKS - 10'h001) ||
                (cur_ff.state != TUNE_RUN && cur_ff.blinkCnt >= BLINK_SLOW_TICKS - 10'h001))
            begin
                nxt_cur.blinkCnt = 10'h000;
                nxt_cur.blinkPhase = !cur_ff.blinkPhase;
            end
            else
            begin
                nxt_cur.blinkCnt = cur_ff.blinkCnt + 10'h001;
            end
        end

        // Indicators
        // Registered, so the lamps trail the sequence by one clock
        case (cur_ff.state)
            TUNE_RUN:
            begin
                nxt_cur.ledGreen = cur_ff.blinkPhase;
                nxt_cur.ledRed = 1'b0;
            end
            TUNE_COMMIT, TUNE_DONE:
            begin
                // Slow flash stands until the next start
                nxt_cur.ledGreen = cur_ff.blinkPhase;
                nxt_cur.ledRed = 1'b0;
            end
            TUNE_FAULT:
            begin
                // Steady red, green dark until the next run
                nxt_cur.ledGreen = 1'b0;
                nxt_cur.ledRed = 1'b1;
            end
            default:
            begin
                // Idle: both lamps dark
                nxt_cur.ledGreen = 1'b0;
                nxt_cur.ledRed = 1'b0;
            end
        endcase

        // Fieldbus: value bits only, top two and parameter bits dropped
        rxValue = busReq.word[VALUE_BIT_MSB:VALUE_BIT_LSB];
        // Feedback is clamped as well, so a reading never passes full scale
        fbValue = (positionFb > FULL_SCALE) ? FULL_SCALE : positionFb;
        // Any answer comes exactly one cycle after the request
        if (busReq.valid)
        begin
            if (!profileFeedback || busReq.code == CODE_PUT_CYCLIC)
            begin
                // Over-range set-points are limited to full scale
                nxt_cur.setPoint = (rxValue > FULL_SCALE) ? FULL_SCALE : rxValue;
                nxt_cur.setPointStb = 1'b1;
            end
            else if (busReq.code == CODE_GET_CYCLIC)
            begin
                // Position sampled in the request's own cycle
                nxt_cur.rsp.word = {2'b00, fbValue};
                nxt_cur.rsp.valid = 1'b1;
            end
        end

        // Extended ID 1: user value in output-only profile, fixed otherwise
        // The user value survives a profile change and comes back
        if (extIdWrite)
        begin
            nxt_cur.extIdUser = extIdData;
        end
        nxt_cur.extId1 = profileFeedback ? EXT_ID1_FIXED : cur_ff.extIdUser;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            // Zero fill first, then the fields reset to named constants
            cur_ff <= '0;
            cur_ff.state <= TUNE_IDLE;
            cur_ff.setPoint <= SET_POINT_RST;
            cur_ff.extIdUser <= EXT_ID1_DEFAULT;
            cur_ff.extId1 <= EXT_ID1_DEFAULT;
        end
        else
        begin
            // One register for the whole state keeps every field in step
            cur_ff <= nxt_cur;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------
    // Nothing combinational reaches a pin, so outputs never glitch
    assign ledGreen = cur_ff.ledGreen;
    assign ledRed = cur_ff.ledRed;
    assign tuneActive = cur_ff.tuneActive;
    assign nvWrite = cur_ff.nvWrite;
    assign nvData = cur_ff.nvData;
    assign busRsp = cur_ff.rsp;
    assign extId1 = cur_ff.extId1;
    assign setPoint = cur_ff.setPoint;
    assign setPointStb = cur_ff.setPointStb;

endmodule
`default_nettype wire

// File: verilog/positioner_pkg.sv
// Shared constants and carrier types for the positioner tuning and fieldbus word logic.
// Assumes a single 40 MHz core clock; the tick cycle count below is derived from it.
package positioner_pkg;

    // ------------------------------------------------------------
    // Clock and time base
    // ------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 40_000_000;      // Core clock rate
    localparam int TICK_TIME_US = 1000;           // Time base tick period, microseconds
    localparam int TICK_CYCLES_DEF = (CLK_FREQ_HZ / 1_000_000) * TICK_TIME_US;
    localparam int TICK_TIME_MS = TICK_TIME_US / 1000;

    // ------------------------------------------------------------
    // Operator timing, in milliseconds and in ticks
    // ------------------------------------------------------------
    localparam int KEY_HOLD_MS = 5000;            // Key hold before a tuning run starts
    localparam logic [12:0] KEY_HOLD_TICKS = 13'(KEY_HOLD_MS / TICK_TIME_MS);
    localparam int BLINK_FAST_MS = 50;            // Half period, very fast flashing
    localparam int BLINK_SLOW_MS = 500;           // Half period, slow flashing
    localparam logic [9:0] BLINK_FAST_TICKS = 10'(BLINK_FAST_MS / TICK_TIME_MS);
    localparam logic [9:0] BLINK_SLOW_TICKS = 10'(BLINK_SLOW_MS / TICK_TIME_MS);

    // ------------------------------------------------------------
    // Fieldbus data word
    // ------------------------------------------------------------
    localparam int VALUE_BIT_LSB = 0;             // Lowest value bit of the word
    localparam int VALUE_BIT_MSB = 13;            // Highest value bit of the word
    localparam logic [13:0] FULL_SCALE = 14'h2710;    // 10000 counts = 100 percent
    localparam logic [3:0] CODE_GET_CYCLIC = 4'h0;    // Master reads feedback
    localparam logic [3:0] CODE_PUT_CYCLIC = 4'h1;    // Master writes set-point
    localparam logic [3:0] EXT_ID1_DEFAULT = 4'h2;    // Arbitrary neutral value
    localparam logic [3:0] EXT_ID1_FIXED = 4'h1;      // Arbitrary neutral value
    localparam logic [13:0] SET_POINT_RST = 14'h0000; // Set-point after reset

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TUNE_IDLE,
        TUNE_RUN,
        TUNE_COMMIT,
        TUNE_DONE,
        TUNE_FAULT
    } tune_state_e;

    // One cyclic fieldbus request from the slave front end
    typedef struct packed {
        logic valid;
        logic [3:0] code;
        logic [15:0] word;
        logic [3:0] params;
    } bus_req_s;

    // One answer word back to the slave front end
    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } bus_rsp_s;

    // Calibration results produced by a tuning run
    typedef struct packed {
        logic [15:0] travelLow;
        logic [15:0] travelHigh;
        logic [15:0] gainOpen;
        logic [15:0] gainClose;
    } tune_result_s;

endpackage

// File: verilog/tick_divider.sv
// Time base divider: emits a one-cycle enable every DIV core clocks.
// Assumes synchronous active-high reset on the same clock.
`timescale 1ns/1ps
`default_nettype none
module tick_divider
    import positioner_pkg::*;
#(
    parameter logic [15:0] DIV = 16'(TICK_CYCLES_DEF)
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Enable output
    output logic tickEn
);

    // Counter plus registered pulse
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } div_state_s;

    div_state_s cur_ff; // Registered state
    div_state_s nxt_cur; // Next state

    // ------------------------------------------------------------
    // Count up and pulse on wrap
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_cur = cur_ff;
        nxt_cur.tick = 1'b0;
        if (cur_ff.cnt >= DIV - 16'h0001)
        begin
            nxt_cur.cnt = 16'h0000;
            nxt_cur.tick = 1'b1;
        end
        else
        begin
            nxt_cur.cnt = cur_ff.cnt + 16'h0001;
        end
    end

    // State register
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            cur_ff <= '0;
        else
            cur_ff <= nxt_cur;
    end

    assign tickEn = cur_ff.tick;

endmodule
`default_nettype wire

// File: sim/fieldbus_master_model.sv
// Fieldbus master model: issues cyclic requests to the positioner word logic.
// Assumes the testbench calls send and idle from one process only.
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master_model
    import positioner_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Request towards the slave
    output var bus_req_s busReq
);
    // Quiet bus after power-up
    initial busReq = '0;

    // One request per call; back-to-back calls give one request per cycle
    task automatic send(input logic [3:0] code, input logic [13:0] value, input logic [3:0] params);
        @(negedge core_clk);
        busReq.valid = 1'h1;
        busReq.code = code;
        busReq.word = {2'h0, value};
        busReq.params = params;
    endtask

    // Release: the stale word is inverted so nothing leans on old data
    task automatic idle();
        @(negedge core_clk);
        busReq.valid = 1'h0;
        busReq.word = ~busReq.word;
        busReq.code = ~busReq.code;
    endtask
endmodule
`default_nettype wire

// File: sim/positioner_checker.sv
// Checker: timing of set-point, feedback, tuning and id outputs.
// Assumes one clock domain and bind from the testbench top.
`timescale 1ns/1ps
`default_nettype none
module positioner_checker
    import positioner_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Panel and tuning
    input wire logic modeManualPin,
    input wire logic ledRed,
    input wire logic cfgTuneStart,
    input wire logic tuneActive,
    input wire logic tuneDone,
    input wire logic tuneFault,
    input wire tune_result_s tuneResult,
    input wire logic nvWrite,
    input wire tune_result_s nvData,
    // Fieldbus
    input wire logic profileFeedback,
    input wire bus_req_s busReq,
    input wire bus_rsp_s busRsp,
    input wire logic extIdWrite,
    input wire logic [3:0] extIdData,
    input wire logic [3:0] extId1,
    input wire logic [13:0] positionFb,
    input wire logic [13:0] setPoint,
    input wire logic setPointStb
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // Full-scale limit applied to every word
    function automatic logic [13:0] clampv(input logic [13:0] v);
        return (v > FULL_SCALE) ? FULL_SCALE : v;
    endfunction

    // ----------------------------------------
    // Step sequences
    // ----------------------------------------
    sequence spReq;
        busReq.valid && (!profileFeedback || busReq.code == CODE_PUT_CYCLIC);
    endsequence
    // Mode seen as manual long enough to pass the synchroniser
    sequence manualHeld;
        modeManualPin [*4] ##0 !tuneActive;
    endsequence
    // Automatic, idle and clear of any commit step
    sequence autoIdle;
        !modeManualPin [*4] ##0 (!tuneActive && !$past(tuneActive) && !$past(tuneActive, 2));
    endsequence
    sequence userIdWr;
        (!profileFeedback && extIdWrite) ##1 (!profileFeedback && !extIdWrite) ##1 !profileFeedback;
    endsequence
    // Good end of a run, with automatic mode seen by the synchroniser
    sequence autoDone;
        !modeManualPin [*3] ##0 (tuneActive && tuneDone && !tuneFault);
    endsequence

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    setpt_update_a: assert property (spReq |=> setPointStb && setPoint == clampv($past(busReq.word[13:0])))
        else $error("set-point not taken from request");
    fb_reply_a: assert property (busReq.valid && profileFeedback && busReq.code == CODE_GET_CYCLIC
        |=> busRsp.valid && busRsp.word == {2'h0, clampv($past(positionFb))})
        else $error("feedback reply wrong");
    code_refuse_a: assert property (busReq.valid && profileFeedback && busReq.code > CODE_PUT_CYCLIC
        |=> !busRsp.valid && !setPointStb) else $error("unknown code answered");
    manual_block_a: assert property (manualHeld ##0 cfgTuneStart |=> !tuneActive)
        else $error("tuning started in manual mode");
    cfg_start_a: assert property (autoIdle ##0 cfgTuneStart |=> tuneActive)
        else $error("software start ignored");
    commit_pulse_a: assert property (autoDone
        |=> !tuneActive ##1 (nvWrite && nvData == $past(tuneResult, 2))) else $error("commit wrong");
    fault_abort_a: assert property (tuneActive && tuneFault |-> ##[1:2] (ledRed && !tuneActive))
        else $error("fault not reported");
    fault_nowrite_a: assert property (tuneActive && tuneFault |=> !nvWrite [*3])
        else $error("store written after fault");
    ext_id_a: assert property (userIdWr |-> extId1 == $past(extIdData, 2))
        else $error("user extended id not reported");
endmodule
`default_nettype wire

// File: sim/positioner_tune_and_fieldbus_word_tb_top.sv
// Testbench: random fieldbus traffic, tuning runs, flash rates, key hold and id.
// Assumes package, master model and checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module positioner_tune_and_fieldbus_word_tb_top
    import positioner_pkg::*;
;
    // Short tick keeps the five-second hold near 20000 cycles
    localparam logic [15:0] TICK = 16'h0004;
    logic core_clk = 1'h0, sys_rst = 1'h1, keyStartPin = 1'h0, modeManualPin = 1'h0;
    logic cfgTuneStart = 1'h0, tuneDone = 1'h0, tuneFault = 1'h0, profileFeedback = 1'h0;
    logic extIdWrite = 1'h0;
    logic [3:0] extIdData = 4'h0;
    logic [13:0] positionFb = 14'h0000;
    tune_result_s tuneResult = '0;
    logic ledGreen, ledRed, tuneActive, nvWrite, setPointStb;
    logic [3:0] extId1;
    logic [13:0] setPoint;
    tune_result_s nvData;
    bus_req_s busReq;
    bus_rsp_s busRsp;
    int miscompares = 0, n_tests = 0, nvCount = 0, expSp = 0, expRw = 0, w, n;
    bit expStb, expRv;
    integer seed = 32'hC92E7882;

    always #12.5 core_clk = ~core_clk;

    positioner_tune_and_fieldbus_word #(.TICK_CYCLES(TICK)) u_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .keyStartPin(keyStartPin),
        .modeManualPin(modeManualPin), .ledGreen(ledGreen), .ledRed(ledRed),
        .cfgTuneStart(cfgTuneStart), .tuneActive(tuneActive), .tuneDone(tuneDone),
        .tuneFault(tuneFault), .tuneResult(tuneResult), .nvWrite(nvWrite), .nvData(nvData),
        .profileFeedback(profileFeedback), .busReq(busReq), .busRsp(busRsp),
        .extIdWrite(extIdWrite), .extIdData(extIdData), .extId1(extId1),
        .positionFb(positionFb), .setPoint(setPoint), .setPointStb(setPointStb));
    fieldbus_master_model u_master (.core_clk(core_clk), .busReq(busReq));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge core_clk);
    endtask
    // Cycles between two green toggles; the first two changes are skipped
    // since the tick phase can make the opening half period a tick short
    task automatic blink(output int c);
        logic l;
        repeat (3)
        begin
            l = ledGreen;
            c = 0;
            while (ledGreen === l && c < 3000)
            begin
                cyc(1);
                c++;
            end
        end
    endtask
    task automatic cfg_start();
        cfgTuneStart = 1'h1;
        cyc(1);
        cfgTuneStart = 1'h0;
    endtask
    // Engine ends the run; result held steady for the store compare
    task automatic end_run(input logic fault);
        tuneDone = !fault;
        tuneFault = fault;
        cyc(1);
        tuneDone = 1'h0;
        tuneFault = 1'h0;
    endtask

    // ----------------------------------------
    // Reference model of the word path, checked every cycle
    // ----------------------------------------
    always @(posedge core_clk)
    begin
        expStb = 0;
        expRv = 0;
        if (sys_rst)
            expSp = 0;
        else if (busReq.valid === 1'h1)
        begin
            w = busReq.word[13:0];
            if (!profileFeedback || busReq.code == 1)
            begin
                expStb = 1;
                expSp = (w > 10000) ? 10000 : w;
            end
            else if (busReq.code == 0)
            begin
                expRv = 1;
                expRw = (positionFb > 10000) ? 10000 : positionFb;
            end
        end
        if (nvWrite === 1'h1)
            nvCount++;
    end
    always @(negedge core_clk)
    begin
        if (!sys_rst)
        begin
            chk(setPointStb, expStb);
            chk(setPoint, expSp);
            chk(busRsp.valid, expRv);
            if (expRv)
                chk(busRsp.word, expRw);
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        cyc(4);
        sys_rst = 1'h0;
        chk({ledGreen, ledRed, tuneActive, nvWrite, extId1}, {4'h0, EXT_ID1_DEFAULT});
        cyc(3);
        // Back-to-back random words in both profiles, codes 0 to 3
        for (int p = 0; p < 2; p++)
        begin
            profileFeedback = p[0];
            repeat (40)
            begin
                u_master.send(4'($random(seed)) & 4'h3, 14'($random(seed)), 4'($random(seed)));
                positionFb = 14'($random(seed));
            end
            u_master.idle();
        end
        profileFeedback = 1'h0;
        cyc(3);
        // User extended id in the output-only profile
        // Top bit set so the user value can never equal the default
        extIdData = 4'($random(seed)) | 4'h8;
        extIdWrite = 1'h1;
        cyc(1);
        extIdWrite = 1'h0;
        cyc(2);
        chk(extId1, extIdData);
        // Feedback profile reports its fixed code instead
        profileFeedback = 1'h1;
        cyc(2);
        chk(extId1, EXT_ID1_FIXED);
        profileFeedback = 1'h0;
        // Manual mode refuses a start
        modeManualPin = 1'h1;
        cyc(4);
        cfg_start();
        cyc(2);
        chk(tuneActive, 1'h0);
        modeManualPin = 1'h0;
        cyc(4);
        // Software start, fast flash, then a fault
        cfg_start();
        chk(tuneActive, 1'h1);
        blink(n);
        chk(n, int'(BLINK_FAST_TICKS) * int'(TICK));
        w = nvCount;
        end_run(1'h1);
        cyc(2);
        chk({ledRed, tuneActive}, 2'h2);
        cyc(3);
        chk(nvCount, w);
        // Retry succeeds, store written, slow flash
        tuneResult = {$random(seed), $random(seed)};
        cfg_start();
        cyc(1);
        chk(ledRed, 1'h0);
        end_run(1'h0);
        chk(tuneActive, 1'h0);
        cyc(1);
        chk(nvWrite, 1'h1);
        chk(nvData, tuneResult);
        blink(n);
        chk(n, int'(BLINK_SLOW_TICKS) * int'(TICK));
        // Short key hold must not start, full hold must
        keyStartPin = 1'h1;
        cyc((int'(KEY_HOLD_TICKS) - 100) * int'(TICK));
        keyStartPin = 1'h0;
        chk(tuneActive, 1'h0);
        cyc(10);
        keyStartPin = 1'h1;
        n = 0;
        while (tuneActive !== 1'h1 && n < 21000)
        begin
            cyc(1);
            n++;
        end
        chk(n >= (int'(KEY_HOLD_TICKS) - 1) * int'(TICK) && n <= int'(KEY_HOLD_TICKS) * int'(TICK) + 4, 1);
        end_run(1'h0);
        // Key still down for more than a full hold time: no second run
        cyc(int'(KEY_HOLD_TICKS) * int'(TICK) + 400);
        chk(tuneActive, 1'h0);
        keyStartPin = 1'h0;
        print_verdict();
    end

    // Watchdog well past the roughly 70000 cycles the sequence needs
    initial
    begin
        repeat (90000) @(posedge core_clk);
        miscompares++;
        print_verdict();
    end
endmodule

bind positioner_tune_and_fieldbus_word positioner_checker u_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .modeManualPin(modeManualPin), .ledRed(ledRed),
    .cfgTuneStart(cfgTuneStart), .tuneActive(tuneActive), .tuneDone(tuneDone),
    .tuneFault(tuneFault), .tuneResult(tuneResult), .nvWrite(nvWrite), .nvData(nvData),
    .profileFeedback(profileFeedback), .busReq(busReq), .busRsp(busRsp),
    .extIdWrite(extIdWrite), .extIdData(extIdData), .extId1(extId1),
    .positionFb(positionFb), .setPoint(setPoint), .setPointStb(setPointStb));
`default_nettype wire
